// ---- rtl/bec_pkg.sv ----
// ----------------------------------------------------------------------------
// Event counter bank constants
// ----------------------------------------------------------------------------
package bec_pkg;

    // Counter slots 0..177 octal
    localparam int BEC_NUM_CTRS = 128;
    localparam logic [6:0] BEC_LAST_NUM = 7'h7f;

    // Value words: octal 1000..1177 (counter number plus 1000 octal)
    localparam logic [15:0] BEC_VAL_BASE = 16'h0200;
    localparam logic [15:0] BEC_VAL_LAST = 16'h027f;

    // Packed done words: octal 41140..41147
    localparam logic [15:0] BEC_DONE_BASE = 16'h4260;
    localparam logic [15:0] BEC_DONE_LAST = 16'h4267;

    // Saturation limits in packed BCD
    localparam logic [15:0] BEC_MAX16 = 16'h9999;
    localparam logic [31:0] BEC_MAX32 = 32'h99999999;
    localparam logic [3:0] BEC_DIGIT_MAX = 4'h9;

    // Instruction kinds issued by the scan
    typedef enum logic [3:0] {
        BEC_KIND_UP = 4'h1,
        BEC_KIND_BIDIR = 4'h2,
        BEC_KIND_STEP = 4'h4,
        BEC_KIND_CLEAR = 4'h8
    } bec_kind_e;

    // Decimal increment over eight packed digits
    function automatic logic [31:0] bec_bcd_inc(input logic [31:0] v);
        logic [31:0] r;
        logic c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (c) begin
                if (r[4*i +: 4] == BEC_DIGIT_MAX) begin
                    r[4*i +: 4] = 4'h0;
                end else begin
                    r[4*i +: 4] = r[4*i +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // Decimal decrement over eight packed digits
    function automatic logic [31:0] bec_bcd_dec(input logic [31:0] v);
        logic [31:0] r;
        logic b;
        r = v;
        b = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (b) begin
                if (r[4*i +: 4] == 4'h0) begin
                    r[4*i +: 4] = BEC_DIGIT_MAX;
                end else begin
                    r[4*i +: 4] = r[4*i +: 4] - 4'h1;
                    b = 1'b0;
                end
            end
        end
        return r;
    endfunction

endpackage

// ---- rtl/bec_counter_bank.sv ----
`timescale 1ns/100ps
`default_nettype none

module bec_counter_bank
    import bec_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic exec,
    input wire logic [3:0] exec_kind,
    input wire logic [6:0] exec_num,
    input wire logic exec_cnt_up,
    input wire logic exec_cnt_dn,
    input wire logic exec_rst,
    input wire logic [31:0] exec_preset,
    input wire logic [15:0] rd_addr,
    output logic res_valid,
    output logic res_done,
    output logic [31:0] res_value,
    output logic exec_err,
    output logic [15:0] rd_data,
    output logic rd_hit
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [BEC_NUM_CTRS-1:0][15:0] val;
        logic [BEC_NUM_CTRS-1:0] done;
        logic [BEC_NUM_CTRS-1:0] prev_up;
        logic [BEC_NUM_CTRS-1:0] prev_dn;
        logic res_valid;
        logic res_done;
        logic [31:0] res_value;
        logic exec_err;
        logic [15:0] rd_data;
        logic rd_hit;
    } bec_state_s;

    bec_state_s s;
    bec_state_s next_s;

    // ------------------------------------------------------------------------
    // Addressed counter view
    // ------------------------------------------------------------------------
    logic [6:0] num_hi;
    logic [31:0] cur_val;
    logic [31:0] inc_val;
    logic [31:0] dec_val;
    logic up_edge;
    logic dn_edge;
    logic [15:0] done_w0;

    // Current value: bidirectional counters span slot n and n+1
    assign num_hi = exec_num + 7'h1;
    assign cur_val = (exec_kind == BEC_KIND_BIDIR) ? {s.val[num_hi], s.val[exec_num]}
                                                   : {16'h0000, s.val[exec_num]};
    assign inc_val = bec_bcd_inc(cur_val);
    assign dec_val = bec_bcd_dec(cur_val);
    // Rising edge against the level seen in the previous scan
    assign up_edge = exec_cnt_up && !s.prev_up[exec_num];
    assign dn_edge = exec_cnt_dn && !s.prev_dn[exec_num];
    assign done_w0 = s.done[15:0];

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // Scan instruction evaluation and read port
    always_comb begin
        logic [31:0] nv;
        nv = cur_val;
        next_s = s;
        next_s.res_valid = 1'b0;
        next_s.exec_err = 1'b0;
        next_s.rd_hit = 1'b0;
        next_s.rd_data = 16'h0000;
        // Value words and packed done words
        if (rd_addr >= BEC_VAL_BASE && rd_addr <= BEC_VAL_LAST) begin
            next_s.rd_hit = 1'b1;
            next_s.rd_data = s.val[rd_addr[6:0]];
        end else if (rd_addr >= BEC_DONE_BASE && rd_addr <= BEC_DONE_LAST) begin
            next_s.rd_hit = 1'b1;
            next_s.rd_data = s.done[{rd_addr[2:0], 4'h0} +: 16];
        end
        if (exec) begin
            next_s.res_valid = 1'b1;
            case (exec_kind)
                BEC_KIND_UP: begin
                    next_s.prev_up[exec_num] = exec_cnt_up;
                    if (exec_rst) begin
                        nv = 32'h0;
                        next_s.done[exec_num] = 1'b0;
                    end else begin
                        if (up_edge && cur_val[15:0] != BEC_MAX16) begin
                            nv = inc_val;
                        end
                        next_s.done[exec_num] = nv[15:0] >= exec_preset[15:0];
                    end
                    next_s.val[exec_num] = nv[15:0];
                end
                BEC_KIND_BIDIR: begin
                    if (exec_num == BEC_LAST_NUM) begin
                        next_s.exec_err = 1'b1;
                        next_s.res_valid = 1'b0;
                    end else begin
                        next_s.prev_up[exec_num] = exec_cnt_up;
                        next_s.prev_dn[exec_num] = exec_cnt_dn;
                        if (exec_rst) begin
                            nv = 32'h0;
                            next_s.done[exec_num] = 1'b0;
                        end else begin
                            // Other input must be off for a count
                            if (up_edge && !exec_cnt_dn && cur_val != BEC_MAX32) begin
                                nv = inc_val;
                            end else if (dn_edge && !exec_cnt_up && cur_val != 32'h0) begin
                                nv = dec_val;
                            end
                            next_s.done[exec_num] = nv >= exec_preset;
                        end
                        next_s.val[exec_num] = nv[15:0];
                        next_s.val[num_hi] = nv[31:16];
                    end
                end
                BEC_KIND_STEP: begin
                    // Reset input ignored: only a clear resets
                    next_s.prev_up[exec_num] = exec_cnt_up;
                    if (up_edge && cur_val[15:0] != BEC_MAX16) begin
                        nv = inc_val;
                    end
                    next_s.done[exec_num] = nv[15:0] >= exec_preset[15:0];
                    next_s.val[exec_num] = nv[15:0];
                end
                BEC_KIND_CLEAR: begin
                    nv = 32'h0;
                    next_s.val[exec_num] = 16'h0000;
                    next_s.done[exec_num] = 1'b0;
                end
                default: begin
                    next_s.exec_err = 1'b1;
                    next_s.res_valid = 1'b0;
                end
            endcase
            next_s.res_value = nv;
            next_s.res_done = next_s.done[exec_num];
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign res_valid = s.res_valid;
    assign res_done = s.res_done;
    assign res_value = s.res_value;
    assign exec_err = s.exec_err;
    assign rd_data = s.rd_data;
    assign rd_hit = s.rd_hit;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // Every digit of a result is decimal
    function automatic logic bec_digits_ok(input logic [31:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (v[4*i +: 4] > BEC_DIGIT_MAX) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    property p_up_reset;
        exec && exec_kind == BEC_KIND_UP && exec_rst |=> res_valid && res_value == 32'h0 && !res_done;
    endproperty
    a_up_reset: assert property (p_up_reset) else $error("up counter reset did not clear");

    property p_up_count;
        exec && exec_kind == BEC_KIND_UP && !exec_rst && up_edge && cur_val[15:0] != BEC_MAX16
            |=> res_value == $past(inc_val);
    endproperty
    a_up_count: assert property (p_up_count) else $error("up counter missed an edge");

    property p_no_edge_hold;
        exec && (exec_kind == BEC_KIND_UP || exec_kind == BEC_KIND_STEP) && !exec_rst && !up_edge
            |=> res_value == $past(cur_val);
    endproperty
    a_no_edge_hold: assert property (p_no_edge_hold) else $error("count without rising edge");

    property p_sat16;
        exec && (exec_kind == BEC_KIND_UP || exec_kind == BEC_KIND_STEP)
            |=> res_value[31:16] == 16'h0000 && res_value[15:0] <= BEC_MAX16;
    endproperty
    a_sat16: assert property (p_sat16) else $error("single-word counter passed 9999");

    property p_done_cmp;
        exec && exec_kind != BEC_KIND_CLEAR && !exec_rst && exec_num != BEC_LAST_NUM
            |=> res_done == (res_value >= $past(exec_preset) || 
                (!($past(exec_kind) == BEC_KIND_BIDIR) && res_value[15:0] >= $past(exec_preset[15:0])));
    endproperty
    a_done_cmp: assert property (p_done_cmp) else $error("done bit disagrees with preset");

    property p_bcd_ok;
        res_valid |-> bec_digits_ok(res_value);
    endproperty
    a_bcd_ok: assert property (p_bcd_ok) else $error("result digit out of range");

    property p_step_ignores_rst;
        exec && exec_kind == BEC_KIND_STEP && exec_rst && !up_edge |=> res_value == $past(cur_val);
    endproperty
    a_step_ignores_rst: assert property (p_step_ignores_rst) else $error("step counter took a reset");

    property p_bidir_down;
        exec && exec_kind == BEC_KIND_BIDIR && exec_num != BEC_LAST_NUM && !exec_rst && dn_edge
            && !exec_cnt_up && cur_val != 32'h0 |=> res_value == $past(dec_val);
    endproperty
    a_bidir_down: assert property (p_bidir_down) else $error("bidirectional counter missed down edge");

    property p_bidir_both;
        exec && exec_kind == BEC_KIND_BIDIR && exec_num != BEC_LAST_NUM && !exec_rst && exec_cnt_up
            && exec_cnt_dn |=> res_value == $past(cur_val);
    endproperty
    a_bidir_both: assert property (p_bidir_both) else $error("count taken with both inputs on");

    property p_bidir_last;
        exec && exec_kind == BEC_KIND_BIDIR && exec_num == BEC_LAST_NUM |=> exec_err && !res_valid;
    endproperty
    a_bidir_last: assert property (p_bidir_last) else $error("bidirectional counter in last slot");

    property p_done_word;
        !exec && rd_addr == BEC_DONE_BASE |=> rd_hit && rd_data == $past(done_w0);
    endproperty
    a_done_word: assert property (p_done_word) else $error("done word read wrong");

    property p_up_past_preset;
        exec && exec_kind == BEC_KIND_UP && !exec_rst && up_edge && cur_val[15:0] != BEC_MAX16
            && cur_val[15:0] >= exec_preset[15:0] |=> res_done && res_value == $past(inc_val);
    endproperty
    a_up_past_preset: assert property (p_up_past_preset) else $error("up counter stopped at preset");

    property p_step_count;
        exec && exec_kind == BEC_KIND_STEP && up_edge && cur_val[15:0] != BEC_MAX16
            |=> res_valid && res_value == $past(inc_val);
    endproperty
    a_step_count: assert property (p_step_count) else $error("step counter missed an edge");

    property p_bidir_up;
        exec && exec_kind == BEC_KIND_BIDIR && exec_num != BEC_LAST_NUM && !exec_rst && up_edge
            && !exec_cnt_dn && cur_val != BEC_MAX32 |=> res_value == $past(inc_val);
    endproperty
    a_bidir_up: assert property (p_bidir_up) else $error("bidirectional counter missed up edge");

    property p_bidir_reset;
        exec && exec_kind == BEC_KIND_BIDIR && exec_num != BEC_LAST_NUM && exec_rst
            |=> res_valid && res_value == 32'h0 && !res_done;
    endproperty
    a_bidir_reset: assert property (p_bidir_reset) else $error("bidirectional reset did not clear");

    property p_clear;
        exec && exec_kind == BEC_KIND_CLEAR |=> res_valid && res_value == 32'h0 && !res_done;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left a count behind");

    property p_value_word;
        rd_addr >= BEC_VAL_BASE && rd_addr <= BEC_VAL_LAST
            |=> rd_hit && rd_data == $past(s.val[rd_addr[6:0]]);
    endproperty
    a_value_word: assert property (p_value_word) else $error("value word read wrong");

    property p_unmapped;
        !(rd_addr >= BEC_VAL_BASE && rd_addr <= BEC_VAL_LAST) && !(rd_addr >= BEC_DONE_BASE && rd_addr <= BEC_DONE_LAST)
            |=> !rd_hit && rd_data == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read returned data");

endmodule

`default_nettype wire

// ---- sim/bec_scan_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module bec_scan_model
    import bec_pkg::*;
(
    input wire logic sys_clk,
    output logic exec,
    output logic [3:0] exec_kind,
    output logic [6:0] exec_num,
    output logic exec_cnt_up,
    output logic exec_cnt_dn,
    output logic exec_rst,
    output logic [31:0] exec_preset
);
    // ------------------------------------------------------------------
    // Scan step driver
    // ------------------------------------------------------------------
    initial begin
        exec = 1'b0;
        exec_kind = 4'h0;
        exec_num = 7'h00;
        exec_cnt_up = 1'b0;
        exec_cnt_dn = 1'b0;
        exec_rst = 1'b0;
        exec_preset = 32'h0;
    end

    // One instruction per scan; lines scrambled once the step is over
    task automatic step(input logic [3:0] k, input logic [6:0] n, input logic u, input logic d,
                        input logic r, input logic [31:0] p);
        @(posedge sys_clk);
        #1;
        exec = 1'b1;
        exec_kind = k;
        exec_num = n;
        exec_cnt_up = u;
        exec_cnt_dn = d;
        exec_rst = r;
        exec_preset = p;
        @(posedge sys_clk);
        #1;
        exec = 1'b0;
        exec_cnt_up = ~u;
        exec_cnt_dn = ~d;
        exec_rst = ~r;
        exec_preset = ~p;
    endtask

    // Low scan before the high scan, unused input held off
    task automatic pulse(input logic [3:0] k, input logic [6:0] n, input logic u, input logic d,
                         input logic [31:0] p);
        step(k, n, 1'b0, 1'b0, 1'b0, p);
        step(k, n, u, d, 1'b0, p);
    endtask
endmodule

`default_nettype wire

// ---- sim/tb_bcd_event_counter_bank.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_bcd_event_counter_bank
    import bec_pkg::*;
;
    logic sys_clk;
    logic rstn;
    logic [15:0] rd_addr;
    wire exec, exec_cnt_up, exec_cnt_dn, exec_rst;
    wire [3:0] exec_kind;
    wire [6:0] exec_num;
    wire [31:0] exec_preset;
    wire res_valid, res_done, exec_err, rd_hit;
    wire [31:0] res_value;
    wire [15:0] rd_data;
    int mismatches = 0;
    int checks = 0;

    bec_scan_model u_scan (.sys_clk(sys_clk), .exec(exec), .exec_kind(exec_kind), .exec_num(exec_num),
        .exec_cnt_up(exec_cnt_up), .exec_cnt_dn(exec_cnt_dn), .exec_rst(exec_rst), .exec_preset(exec_preset));
    bec_counter_bank u_dut (.sys_clk(sys_clk), .rstn(rstn), .exec(exec), .exec_kind(exec_kind),
        .exec_num(exec_num), .exec_cnt_up(exec_cnt_up), .exec_cnt_dn(exec_cnt_dn), .exec_rst(exec_rst),
        .exec_preset(exec_preset), .rd_addr(rd_addr), .res_valid(res_valid), .res_done(res_done),
        .res_value(res_value), .exec_err(exec_err), .rd_data(rd_data), .rd_hit(rd_hit));

    // ------------------------------------------------------------------
    // Compare helpers
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic res(input logic [31:0] v, input logic d);
        chk("res_valid", 32'h1, {31'h0, res_valid});
        chk("res_value", v, res_value);
        chk("res_done", {31'h0, d}, {31'h0, res_done});
    endtask

    task automatic rd(input logic [15:0] a, input logic h, input logic [15:0] exp);
        @(posedge sys_clk);
        #1;
        rd_addr = a;
        @(posedge sys_clk);
        #1;
        chk("read", {15'h0, h, exp}, {15'h0, rd_hit, rd_data});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_up();
        for (int i = 1; i <= 4; i++) begin
            u_scan.pulse(BEC_KIND_UP, 7'd2, 1'b1, 1'b0, 32'h3);
            res(i, i >= 3);
        end
        u_scan.step(BEC_KIND_UP, 7'd2, 1'b1, 1'b0, 1'b0, 32'h3);
        res(32'h4, 1'b1);
        rd(16'h0202, 1'b1, 16'h0004);
        rd(16'h4260, 1'b1, 16'h0004);
        rd(16'h0300, 1'b0, 16'h0000);
        u_scan.step(BEC_KIND_UP, 7'd2, 1'b1, 1'b0, 1'b1, 32'h0);
        res(32'h0, 1'b0);
    endtask

    task automatic t_sat();
        for (int i = 1; i <= 9999; i++) begin
            u_scan.pulse(BEC_KIND_UP, 7'd5, 1'b1, 1'b0, 32'h9999);
            if (i == 10) res(32'h10, 1'b0);
        end
        res(32'h9999, 1'b1);
        u_scan.pulse(BEC_KIND_UP, 7'd5, 1'b1, 1'b0, 32'h9999);
        res(32'h9999, 1'b1);
        rd(16'h0205, 1'b1, 16'h9999);
    endtask

    task automatic t_bidir();
        for (int i = 0; i < 3; i++) u_scan.pulse(BEC_KIND_BIDIR, 7'd10, 1'b1, 1'b0, 32'h2);
        res(32'h3, 1'b1);
        u_scan.pulse(BEC_KIND_BIDIR, 7'd10, 1'b0, 1'b1, 32'h2);
        res(32'h2, 1'b1);
        for (int i = 0; i < 8; i++) u_scan.pulse(BEC_KIND_BIDIR, 7'd10, 1'b1, 1'b0, 32'h2);
        u_scan.pulse(BEC_KIND_BIDIR, 7'd10, 1'b0, 1'b1, 32'h2);
        res(32'h9, 1'b1);
        u_scan.pulse(BEC_KIND_BIDIR, 7'd10, 1'b1, 1'b1, 32'h2);
        res(32'h9, 1'b1);
        for (int i = 0; i < 10; i++) u_scan.pulse(BEC_KIND_BIDIR, 7'd10, 1'b0, 1'b1, 32'h2);
        res(32'h0, 1'b0);
        u_scan.pulse(BEC_KIND_BIDIR, 7'd10, 1'b1, 1'b0, 32'h2);
        res(32'h1, 1'b0);
        u_scan.step(BEC_KIND_BIDIR, 7'd10, 1'b0, 1'b0, 1'b1, 32'h2);
        res(32'h0, 1'b0);
        rd(16'h020b, 1'b1, 16'h0000);
        u_scan.step(BEC_KIND_BIDIR, 7'd127, 1'b1, 1'b0, 1'b0, 32'h2);
        chk("err", 32'h3, {30'h0, exec_err, ~res_valid});
        u_scan.step(4'h3, 7'd1, 1'b1, 1'b0, 1'b0, 32'h2);
        chk("err", 32'h3, {30'h0, exec_err, ~res_valid});
    endtask

    task automatic t_step();
        for (int i = 0; i < 2; i++) u_scan.pulse(BEC_KIND_STEP, 7'd7, 1'b1, 1'b0, 32'h2);
        res(32'h2, 1'b1);
        u_scan.step(BEC_KIND_STEP, 7'd7, 1'b0, 1'b0, 1'b1, 32'h2);
        res(32'h2, 1'b1);
        u_scan.step(BEC_KIND_CLEAR, 7'd7, 1'b0, 1'b0, 1'b0, 32'h0);
        res(32'h0, 1'b0);
        rd(16'h0207, 1'b1, 16'h0000);
        rd(16'h4260, 1'b1, 16'h0020);
        u_scan.pulse(BEC_KIND_STEP, 7'd7, 1'b1, 1'b0, 32'h2);
        res(32'h1, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // Verdict, clock, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        #480000;
        mismatches++;
        give_verdict();
    end

    initial begin
        rstn = 1'b0;
        rd_addr = 16'h0;
        repeat (3) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        t_up();
        t_sat();
        t_bidir();
        t_step();
        give_verdict();
    end
endmodule

`default_nettype wire
